/* hw/rt_bus_select_pkg.sv */
// constants shared by the bus-select, mode-select and transmit fifo logic
package rt_bus_select_pkg;

  // data path and fifo geometry
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;
  localparam int ADDR_W = 4;

  // register port addresses; bit 3 of the address is a don't-care for decode
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_FIFO_STATUS = 3'h1;
  localparam logic [2:0] ADDR_TX_FIFO = 3'h2;
  localparam logic [2:0] ADDR_TX_LOAD = 3'h3;
  localparam logic [2:0] ADDR_BUS_A_WORD = 3'h6;
  localparam logic [2:0] ADDR_BUS_B_WORD = 3'h7;

  // control register field positions
  localparam int CTRL_MASTER_RESET = 0;
  localparam int CTRL_SPARE = 1;
  localparam int CTRL_CONTROLLER_MODE = 2;
  localparam int CTRL_TERMINAL_MODE = 3;
  localparam int CTRL_BUS_A_TX = 4;
  localparam int CTRL_BUS_B_TX = 5;

  // reset values
  localparam logic [WORD_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  // operating modes, one-hot
  typedef enum logic [3:0] {
    MODE_MT_ADDR = 4'h1,
    MODE_BC = 4'h2,
    MODE_RT = 4'h4,
    MODE_MT_NOADDR = 4'h8
  } op_mode_t;

  // bus index
  localparam int BUS_A = 0;
  localparam int BUS_B = 1;
  localparam int NUM_BUS = 2;

endpackage

/* hw/tx_word_fifo.sv */
// transmit data word fifo held in flip-flops
`timescale 1ns/1ps
module tx_word_fifo
  import rt_bus_select_pkg::*;
(
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic push_i,
  input wire logic [WORD_W-1:0] push_data_i,
  input wire logic pop_i,
  output logic [WORD_W-1:0] head_o,
  output logic valid_o,
  output logic full_o,
  output logic [FIFO_AW:0] count_o
);

  logic [WORD_W-1:0] mem_reg [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_ptr_reg;
  logic [FIFO_AW-1:0] rd_ptr_reg;
  logic [FIFO_AW:0] count_reg;
  logic do_push;
  logic do_pop;

  // a push into a full fifo is dropped; words leave in load order
  assign full_o = (count_reg == FIFO_DEPTH[FIFO_AW:0]);
  assign valid_o = (count_reg != '0);
  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && valid_o;
  assign head_o = mem_reg[rd_ptr_reg];
  assign count_o = count_reg;

  // pointers and occupancy; clear beats any push or pop in the same cycle
  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (ce_i) begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 5'h01;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 5'h01;
      end
      count_reg <= count_reg + {5'h00, do_push} - {5'h00, do_pop};
    end
  end

  // storage; stale words need no clearing since the pointers hide them
  always_ff @(posedge clk_i) begin
    if (ce_i && do_push && !clear_i) begin
      mem_reg[wr_ptr_reg] <= push_data_i;
    end
  end

endmodule

/* hw/rt_bus_select.sv */
// bus transmit enables, mode select, master reset, transmit fifo and per-bus word registers
`timescale 1ns/1ps

// Contract
// - one enable bit set transmits on that bus
// - both enable bits set selects neither bus
// - protocol engine sees only the active bus
// - inactive bus decoder and indication keep working
// - inactive bus word readable, no transmit there
// - inhibit pins override transmit enable bits
// - mode selects are bit OR pin
// - mode pair decodes to four operating modes
// - control bit 1 has no function
// - bit 0 high acts as master reset pin
// - master reset clears all but control register
// - transmit fifo holds thirty-two words
// - words leave in load order
// - fifo cleared by reset, valid, error, write
// - per-bus register keeps last valid word received in RT mode
module rt_bus_select
  import rt_bus_select_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // host register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [WORD_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [WORD_W-1:0] reg_rdata_o,
  // control pins
  input wire logic master_reset_i,
  input wire logic terminal_mode_select_i,
  input wire logic controller_mode_select_i,
  input wire logic bus_a_tx_inhibit_i,
  input wire logic bus_b_tx_inhibit_i,
  // manchester decoders
  input wire logic [WORD_W-1:0] dec_a_word_i,
  input wire logic dec_a_word_valid_i,
  input wire logic dec_a_cmd_i,
  input wire logic [WORD_W-1:0] dec_b_word_i,
  input wire logic dec_b_word_valid_i,
  input wire logic dec_b_cmd_i,
  // protocol engine
  input wire logic message_valid_i,
  input wire logic error_i,
  output logic [WORD_W-1:0] engine_word_o,
  output logic engine_word_valid_o,
  output logic active_bus_a_o,
  output logic active_bus_b_o,
  output logic master_reset_o,
  // operating mode
  output logic mode_mt_addr_o,
  output logic mode_bc_o,
  output logic mode_rt_o,
  output logic mode_mt_noaddr_o,
  // encoder side
  input wire logic tx_word_pop_i,
  output logic [WORD_W-1:0] tx_word_o,
  output logic tx_word_valid_o,
  output logic bus_a_tx_enable_o,
  output logic bus_b_tx_enable_o,
  output logic receive_indication_a_o,
  output logic receive_indication_b_o,
  output logic fifo_full_o
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // bit 3 of the address is ignored so every decode shares this helper
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [2:0] target);
    addr_hit = (addr[2:0] == target);
  endfunction

  // write strobes and read mux for the register port
  logic wr_control;
  logic wr_fifo;
  logic wr_load;
  logic [WORD_W-1:0] rd_mux;

  assign wr_control = reg_wr_i && addr_hit(reg_addr_i, ADDR_CONTROL);
  assign wr_fifo = reg_wr_i && addr_hit(reg_addr_i, ADDR_TX_FIFO);
  // loads have their own address, because any write to the clear address empties the fifo
  assign wr_load = reg_wr_i && addr_hit(reg_addr_i, ADDR_TX_LOAD);

  ////////////////////////////////////////////////////////////////////////////
  // control register

  // held value and its next value; bit 0 doubles as the software master reset
  logic [WORD_W-1:0] control_reg;
  logic [WORD_W-1:0] control_next;
  logic mr_active;

  assign control_next = wr_control ? reg_wdata_i : control_reg;

  // only reset_i clears it; master reset leaves it alone
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      control_reg <= CTRL_RESET;
    end else if (ce_i) begin
      control_reg <= control_next;
    end
  end

  // bit 0 held high behaves just like the pin held high, so 1 then 0 is a pulse
  assign mr_active = master_reset_i || control_reg[CTRL_MASTER_RESET];
  assign master_reset_o = mr_active;

  // the spare bit is stored and read back but steers nothing: no decode
  // below looks at it, so it has no function in remote-terminal mode or any other

  ////////////////////////////////////////////////////////////////////////////
  // operating mode

  // a pin or a bit may select a mode; neither can take back what the other selects
  logic term_sel;
  logic ctrl_sel;
  logic rt_mode;
  op_mode_t mode;

  assign term_sel = control_reg[CTRL_TERMINAL_MODE] || terminal_mode_select_i;
  assign ctrl_sel = control_reg[CTRL_CONTROLLER_MODE] || controller_mode_select_i;

  // every pair of selects is a legal mode, so no default is needed
  always_comb begin
    unique case ({term_sel, ctrl_sel})
      2'b00: mode = MODE_MT_ADDR;
      2'b01: mode = MODE_BC;
      2'b10: mode = MODE_RT;
      2'b11: mode = MODE_MT_NOADDR;
    endcase
  end

  assign mode_mt_addr_o = (mode == MODE_MT_ADDR);
  assign mode_bc_o = (mode == MODE_BC);
  assign rt_mode = (mode == MODE_RT);
  assign mode_rt_o = rt_mode;
  assign mode_mt_noaddr_o = (mode == MODE_MT_NOADDR);

  ////////////////////////////////////////////////////////////////////////////
  // bus selection and transmit enables

  // bus select taken straight from the two enable bits
  logic sel_a;
  logic sel_b;

  // exactly one enable bit names the active bus; both or none select nothing
  assign sel_a = control_reg[CTRL_BUS_A_TX] && !control_reg[CTRL_BUS_B_TX];
  assign sel_b = control_reg[CTRL_BUS_B_TX] && !control_reg[CTRL_BUS_A_TX];
  assign active_bus_a_o = sel_a;
  assign active_bus_b_o = sel_b;

  // inhibit pins win over the enable bits; the inactive bus never transmits
  assign bus_a_tx_enable_o = sel_a && !bus_a_tx_inhibit_i;
  assign bus_b_tx_enable_o = sel_b && !bus_b_tx_inhibit_i;

  ////////////////////////////////////////////////////////////////////////////
  // per-bus receive path

  // array views of the two decoder ports so the generate loop can index them
  logic [WORD_W-1:0] dec_word [NUM_BUS];
  logic dec_valid [NUM_BUS];
  logic dec_cmd [NUM_BUS];
  logic [WORD_W-1:0] bus_word_reg [NUM_BUS];
  logic rcv_reg [NUM_BUS];

  assign dec_word[BUS_A] = dec_a_word_i;
  assign dec_word[BUS_B] = dec_b_word_i;
  assign dec_valid[BUS_A] = dec_a_word_valid_i;
  assign dec_valid[BUS_B] = dec_b_word_valid_i;
  assign dec_cmd[BUS_A] = dec_a_cmd_i;
  assign dec_cmd[BUS_B] = dec_b_cmd_i;

  // both buses run regardless of which is active, so a command on the
  // standby bus still raises its indication and, in remote-terminal mode, updates its word register
  for (genvar b = 0; b < NUM_BUS; b++) begin : g_bus
    always_ff @(posedge clk_i) begin
      if (reset_i || mr_active) begin
        bus_word_reg[b] <= WORD_RESET;
        rcv_reg[b] <= 1'b0;
      end else if (ce_i) begin
        rcv_reg[b] <= dec_cmd[b];
        if (dec_valid[b] && rt_mode) begin
          bus_word_reg[b] <= dec_word[b];
        end
      end
    end
  end

  assign receive_indication_a_o = rcv_reg[BUS_A];
  assign receive_indication_b_o = rcv_reg[BUS_B];

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine attachment

  // registered hand-off to the protocol engine
  logic [WORD_W-1:0] engine_word_reg;
  logic engine_valid_reg;
  logic [WORD_W-1:0] engine_word_next;
  logic engine_valid_next;

  // the engine is fed from the active bus only; with no bus selected it sees nothing
  assign engine_word_next = sel_b ? dec_b_word_i : dec_a_word_i;
  assign engine_valid_next = (sel_a && dec_a_word_valid_i) || (sel_b && dec_b_word_valid_i);

  always_ff @(posedge clk_i) begin
    if (reset_i || mr_active) begin
      engine_word_reg <= WORD_RESET;
      engine_valid_reg <= 1'b0;
    end else if (ce_i) begin
      engine_valid_reg <= engine_valid_next;
      if (engine_valid_next) begin
        engine_word_reg <= engine_word_next;
      end
    end
  end

  assign engine_word_o = engine_word_reg;
  assign engine_word_valid_o = engine_valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // transmit fifo and its clearing events

  // edge detectors for the two clearing levels, plus the fifo strobes
  logic valid_seen_reg;
  logic error_seen_reg;
  logic valid_rise;
  logic error_rise;
  logic clear_event;
  logic fifo_clear;
  logic fifo_push;
  logic [FIFO_AW:0] fifo_count;

  // clear on the assertion edge, so a long message-valid level does not
  // wipe words that the host loads for the next message
  assign valid_rise = message_valid_i && !valid_seen_reg;
  assign error_rise = error_i && !error_seen_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i || mr_active) begin
      valid_seen_reg <= 1'b0;
      error_seen_reg <= 1'b0;
    end else if (ce_i) begin
      valid_seen_reg <= message_valid_i;
      error_seen_reg <= error_i;
    end
  end

  // a write to the fifo address empties it; the written data is discarded
  assign clear_event = valid_rise || error_rise || wr_fifo;
  assign fifo_clear = reset_i || mr_active || (ce_i && clear_event);

  // the host loading path: words land at the tail and leave from the head
  // meeting the mid-parity deadline is the host's job; a late word just misses
  assign fifo_push = wr_load;

  // a pop on an empty fifo and a load into a full one are both ignored
  tx_word_fifo u_tx_fifo (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .clear_i(fifo_clear),
    .push_i(fifo_push),
    .push_data_i(reg_wdata_i),
    .pop_i(tx_word_pop_i),
    .head_o(tx_word_o),
    .valid_o(tx_word_valid_o),
    .full_o(fifo_full_o),
    .count_o(fifo_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read port

  // status word: occupancy in the low bits, full flag above it
  logic [WORD_W-1:0] fifo_status;
  assign fifo_status = {9'h000, fifo_full_o, fifo_count};

  assign rd_mux = addr_hit(reg_addr_i, ADDR_CONTROL) ? control_reg :
                  addr_hit(reg_addr_i, ADDR_FIFO_STATUS) ? fifo_status :
                  addr_hit(reg_addr_i, ADDR_BUS_A_WORD) ? bus_word_reg[BUS_A] :
                  addr_hit(reg_addr_i, ADDR_BUS_B_WORD) ? bus_word_reg[BUS_B] :
                  WORD_RESET;

  // registered so the host sees a word that cannot change under it
  logic [WORD_W-1:0] rdata_reg;

  // read data is held until the next read strobe, reset or master reset
  always_ff @(posedge clk_i) begin
    if (reset_i || mr_active) begin
      rdata_reg <= WORD_RESET;
    end else if (ce_i && reg_rd_i) begin
      rdata_reg <= rd_mux;
    end
  end

  assign reg_rdata_o = rdata_reg;

endmodule

/* hw/load_fix_note.sv */
// holds no logic; the transmit fifo load path is part of rt_bus_select

/* dv/rt_bus_select_sva.sv */
// port assertions for the bus select, mode select and transmit fifo block
`timescale 1ns/1ps
module rt_bus_select_sva
  import rt_bus_select_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic master_reset_i,
  input wire logic terminal_mode_select_i,
  input wire logic controller_mode_select_i,
  input wire logic bus_a_tx_inhibit_i,
  input wire logic [WORD_W-1:0] dec_a_word_i,
  input wire logic dec_a_word_valid_i,
  input wire logic dec_a_cmd_i,
  input wire logic dec_b_word_valid_i,
  input wire logic message_valid_i,
  input wire logic [WORD_W-1:0] engine_word_o,
  input wire logic engine_word_valid_o,
  input wire logic active_bus_a_o,
  input wire logic active_bus_b_o,
  input wire logic master_reset_o,
  input wire logic mode_mt_addr_o,
  input wire logic mode_bc_o,
  input wire logic mode_rt_o,
  input wire logic mode_mt_noaddr_o,
  input wire logic tx_word_valid_o,
  input wire logic bus_a_tx_enable_o,
  input wire logic bus_b_tx_enable_o,
  input wire logic receive_indication_a_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////////////
  // bus selection and transmit enables
  a_one_bus_only: assert property (!(active_bus_a_o && active_bus_b_o)
    && !(bus_a_tx_enable_o && bus_b_tx_enable_o))
    else $error("two buses active at once");
  a_tx_a_cause: assert property (bus_a_tx_enable_o == (active_bus_a_o && !bus_a_tx_inhibit_i))
    else $error("bus a enable not active and uninhibited");
  // mode decode: pins can only add to the register bits
  a_mode_onehot: assert property ($onehot({mode_mt_addr_o, mode_bc_o, mode_rt_o, mode_mt_noaddr_o}))
    else $error("mode outputs not one-hot");
  a_mode_pins_or: assert property ((!terminal_mode_select_i || mode_rt_o || mode_mt_noaddr_o)
    && (!controller_mode_select_i || mode_bc_o || mode_mt_noaddr_o))
    else $error("mode pin ignored");
  a_mr_pin_follow: assert property (master_reset_i |-> master_reset_o)
    else $error("master reset pin not passed on");
  a_fifo_clear_evt: assert property (master_reset_o || ($rose(message_valid_i) && ce_i)
    |=> !tx_word_valid_o)
    else $error("fifo not empty after clear event");
  // decoder traffic: inactive bus still flags, engine hears only the active bus
  a_rcv_ind_kept: assert property (ce_i && !master_reset_o && dec_a_cmd_i |=> receive_indication_a_o)
    else $error("receive indication missing");
  a_engine_active: assert property (ce_i && !master_reset_o && mode_rt_o && active_bus_a_o
    && dec_a_word_valid_i |=> engine_word_valid_o && engine_word_o == $past(dec_a_word_i))
    else $error("active bus word not passed to engine");
  a_engine_quiet: assert property (ce_i && dec_b_word_valid_i && !active_bus_b_o && !dec_a_word_valid_i
    |=> !engine_word_valid_o)
    else $error("inactive bus word reached engine");
endmodule
bind rt_bus_select rt_bus_select_sva i_sva (.clk_i, .reset_i, .ce_i, .master_reset_i, .terminal_mode_select_i,
  .controller_mode_select_i, .bus_a_tx_inhibit_i, .dec_a_word_i, .dec_a_word_valid_i, .dec_a_cmd_i, .dec_b_word_valid_i,
  .message_valid_i, .engine_word_o, .engine_word_valid_o, .active_bus_a_o, .active_bus_b_o, .master_reset_o,
  .mode_mt_addr_o, .mode_bc_o, .mode_rt_o, .mode_mt_noaddr_o, .tx_word_valid_o, .bus_a_tx_enable_o,
  .bus_b_tx_enable_o, .receive_indication_a_o);

/* dv/host_port_model.sv */
// host controller model driving the register port
`timescale 1ns/1ps
module host_port_model
  import rt_bus_select_pkg::*;
(
  input wire logic clk_i,
  input wire logic [WORD_W-1:0] reg_rdata_i,
  output logic [ADDR_W-1:0] reg_addr_o = 4'h0,
  output logic [WORD_W-1:0] reg_wdata_o = 16'h0000,
  output logic reg_wr_o = 1'b0,
  output logic reg_rd_o = 1'b0
);
  // strobe for one cycle; address and data invert once taken so stale values never look valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
  // read data is registered at the taking edge, so it is settled by the next falling edge
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    d = reg_rdata_i;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
  endtask
  // software master reset: bit 0 written one then zero, other control bits kept
  task automatic pulse_mr(input logic [WORD_W-1:0] ctrl);
    wr(4'h0, ctrl | 16'h0001);
    wr(4'h0, ctrl & 16'hfffe);
  endtask
endmodule

/* dv/rt_bus_select_tb.sv */
// testbench for the bus select, mode select and transmit fifo block
`timescale 1ns/1ps
module rt_bus_select_tb;
  import rt_bus_select_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr;
  logic [WORD_W-1:0] reg_wdata, reg_rdata, rd_val, tx_word, engine_word;
  logic [WORD_W-1:0] dec_a_word = 16'h0000, dec_b_word = 16'h0000;
  logic reg_wr, reg_rd, mr_pin = 0, term_pin = 0, ctrl_pin = 0, inh_a = 0, inh_b = 0, msg_valid = 0, err = 0;
  logic dec_a_valid = 0, dec_a_cmd = 0, dec_b_valid = 0, dec_b_cmd = 0;
  logic pop = 0, ce = 1;
  logic ew_valid, act_a, act_b, mr_o, tx_valid, tx_a, tx_b, ri_a, ri_b, full;
  logic [3:0] modes;
  logic [3:0] en_exp [4] = '{4'h0, 4'ha, 4'h5, 4'h0};
  int errors = 0;
  int n_checks = 0;
  always #4 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  host_port_model i_host (.clk_i(clk_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd));
  // clock enable and encoder pop are driven so that freezing and load order can both be seen
  rt_bus_select i_dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .master_reset_i(mr_pin),
    .terminal_mode_select_i(term_pin), .controller_mode_select_i(ctrl_pin), .bus_a_tx_inhibit_i(inh_a),
    .bus_b_tx_inhibit_i(inh_b), .dec_a_word_i(dec_a_word), .dec_a_word_valid_i(dec_a_valid), .dec_a_cmd_i(dec_a_cmd),
    .dec_b_word_i(dec_b_word), .dec_b_word_valid_i(dec_b_valid), .dec_b_cmd_i(dec_b_cmd), .message_valid_i(msg_valid),
    .error_i(err), .engine_word_o(engine_word), .engine_word_valid_o(ew_valid), .active_bus_a_o(act_a),
    .active_bus_b_o(act_b), .master_reset_o(mr_o), .mode_mt_addr_o(modes[0]), .mode_bc_o(modes[1]),
    .mode_rt_o(modes[2]), .mode_mt_noaddr_o(modes[3]), .tx_word_pop_i(pop), .tx_word_o(tx_word),
    .tx_word_valid_o(tx_valid), .bus_a_tx_enable_o(tx_a), .bus_b_tx_enable_o(tx_b), .receive_indication_a_o(ri_a),
    .receive_indication_b_o(ri_b), .fifo_full_o(full));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a hang of the register port ends the run as a failure
  initial begin
    #20000;
    errors++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    @(negedge clk_i) reset_i = 1'b0;
    // enable pairs none, a, b, both
    for (int k = 0; k < 4; k++) begin
      i_host.wr(4'h0, 16'(k) << 4);
      chk("enables", 16'(en_exp[k]), 16'({act_a, act_b, tx_a, tx_b}));
    end
    // inhibit pin beats the enable bit
    for (int b = 0; b < 2; b++) begin
      i_host.wr(4'h0, 16'h0010 << b);
      {inh_b, inh_a} = 2'b01 << b;
      @(negedge clk_i);
      chk("inhibit", 16'(4'b1000 >> b), 16'({act_a, act_b, tx_a, tx_b}));
      {inh_b, inh_a} = 2'b00;
    end
    // every mode pair, first from register bits, then from pins
    for (int k = 0; k < 8; k++) begin
      i_host.wr(4'h0, (k < 4) ? 16'(k[1:0]) << 2 : 16'h0000);
      {term_pin, ctrl_pin} = (k < 4) ? 2'b00 : k[1:0];
      @(negedge clk_i);
      chk("mode", 16'(4'h1 << k[1:0]), 16'(modes));
    end
    {term_pin, ctrl_pin} = 2'b00;
    i_host.wr(4'h0, 16'h001a);
    chk("rt with spare bit", 16'h0004, 16'(modes));
    // command on the inactive bus b, then a word on active bus a
    {dec_b_word, dec_b_valid, dec_b_cmd} = {16'h1234, 2'b11};
    @(negedge clk_i);
    {dec_b_word, dec_b_valid, dec_b_cmd} = {16'hedcb, 2'b00};
    chk("rcv b", 16'h0001, 16'({ri_a, ri_b}));
    chk("no engine word", 16'h0000, 16'({ew_valid, tx_b}));
    i_host.rd(4'h7, rd_val);
    chk("bus b word", 16'h1234, rd_val);
    {dec_a_word, dec_a_valid, dec_a_cmd} = {16'ha5a5, 2'b11};
    @(negedge clk_i);
    {dec_a_word, dec_a_valid, dec_a_cmd} = {16'h5a5a, 2'b00};
    chk("engine word", 16'ha5a5, engine_word);
    chk("engine valid and rcv a", 16'h0006, 16'({ew_valid, ri_a, ri_b}));
    i_host.rd(4'he, rd_val);
    chk("bus a word", 16'ha5a5, rd_val);
    i_host.rd(4'h3, rd_val);
    chk("unmapped", 16'h0000, rd_val);
    // fill the fifo to its depth; one more load is dropped
    for (int i = 0; i < 33; i++) begin
      i_host.wr(4'h3, 16'h0100 + 16'(i));
    end
    i_host.rd(4'h1, rd_val);
    chk("fifo status full", 16'h0060, rd_val);
    chk("fifo full flag", 16'h0001, 16'(full));
    // a frozen clock enable holds the head although the encoder pops
    {ce, pop} = 2'b01;
    @(negedge clk_i);
    chk("frozen head", 16'h0100, tx_word);
    {ce, pop} = 2'b11;
    for (int i = 0; i < 32; i++) begin
      chk("fifo order", 16'h0100 + 16'(i), tx_word);
      @(negedge clk_i);
    end
    pop = 1'b0;
    chk("fifo drained", 16'h0000, 16'({tx_valid, full}));
    // fifo clearing by write at x010, by message valid and by error
    i_host.wr(4'h3, 16'h0055);
    i_host.wr(4'ha, 16'hffff);
    i_host.rd(4'h1, rd_val);
    chk("fifo status", 16'h0000, rd_val);
    for (int b = 0; b < 2; b++) begin
      i_host.wr(4'h3, 16'h0066);
      chk("fifo loaded", 16'h0001, 16'(tx_valid));
      {err, msg_valid} = 2'b01 << b;
      @(negedge clk_i);
      chk("fifo empty", 16'h0000, 16'(tx_valid));
      {err, msg_valid} = 2'b00;
    end
    // master reset by bit keeps only the control register; by pin it reaches the mr output
    i_host.wr(4'h3, 16'h0077);
    i_host.pulse_mr(16'h001a);
    chk("fifo after mr", 16'h0000, 16'(tx_valid));
    i_host.rd(4'h6, rd_val);
    chk("word after mr", 16'h0000, rd_val);
    i_host.rd(4'h0, rd_val);
    chk("control after mr", 16'h001a, rd_val);
    mr_pin = 1'b1;
    @(negedge clk_i);
    chk("mr out", 16'h0001, 16'(mr_o));
    mr_pin = 1'b0;
    @(negedge clk_i);
    // a mid-run reset clears the control register as well
    reset_i = 1'b1;
    @(negedge clk_i);
    reset_i = 1'b0;
    i_host.rd(4'h0, rd_val);
    chk("control after reset", 16'h0000, rd_val);
    chk("modes after reset", 16'h0001, 16'(modes));
    wrap_up();
  end
endmodule
